// *** rtl/osc_startup_release.v ***
// Behaviour
// - Crystal modes hold the program counter for 1024 oscillator cycles
// - Count starts after power-up delay, or on wake
// - Program counter and execution held while counting
// - External clock mode frees second pin as I/O
// - External clock mode skips the start-up count
// - Stopped oscillator pin holds the start-up count unchanged
// - Crystal modes select low, mid, high gain
// - Interrupt wake with global enable loads vector 0004h
// - Wake leaves source flag bits set
// - Brown-out and nrst clear cause bit 0, others keep it
`timescale 1ns/10ps
`include "osc_startup_map.vh"
module osc_startup_release #(
   parameter STARTUP_CYCLES = `STARTUP_CYCLES
) (
   input  wire                 sys_clk,
   input  wire                 nrst,
   input  wire [`MODE_W-1:0]   osc_mode,
   input  wire                 osc_in_pin,
   input  wire                 por_event,
   input  wire                 bor_event,
   input  wire                 other_reset_event,
   input  wire                 pwrup_timer_enable,
   input  wire                 pwrup_timer_done,
   input  wire                 sleep_wake_event,
   input  wire                 wake_by_irq,
   input  wire                 global_irq_enable,
   input  wire [7:0]           wake_src_ctrl,
   input  wire [7:0]           wake_src_a,
   input  wire [7:0]           wake_src_b,
   input  wire                 bor_flag_set,
   output reg                  core_reset,
   output reg                  pc_hold,
   output reg                  pc_load,
   output reg  [`PC_W-1:0]     pc_load_value,
   output reg  [1:0]           amp_gain,
   output reg                  osc_out_gpio_en,
   output reg  [7:0]           irq_control_reg,
   output reg  [7:0]           periph_flag_reg_a,
   output reg  [7:0]           periph_flag_reg_b,
   output reg                  reset_cause_bor_n,
   output reg                  startup_busy,
   output reg  [`CNT_W-1:0]    startup_cycle_counter
);
   localparam [`CNT_W-1:0] TERMINAL = STARTUP_CYCLES;

   reg  [`ST_W-1:0] state_reg;
   reg  [`ST_W-1:0] state_next;
   reg              irq_vec_pending_reg;
   wire             osc_rise;
   wire             ext_mode;
   wire             any_reset;
   wire             pwrup_ok;

   edge_rise_detect u_osc_edge (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .level_in   (osc_in_pin),
      .rise_pulse (osc_rise)
   );

   assign ext_mode  = (osc_mode == `EXT_CLOCK_MODE);
   assign any_reset = por_event | bor_event | other_reset_event;
   assign pwrup_ok  = ~pwrup_timer_enable | pwrup_timer_done;

   // Gain select and pin release follow the mode fuse
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         amp_gain        <= `GAIN_OFF;
         osc_out_gpio_en <= 1'b0;
      end else begin
         osc_out_gpio_en <= ext_mode;
         case (osc_mode)
            `LOW_GAIN_MODE:  amp_gain <= `GAIN_LOW;
            `MID_GAIN_MODE:  amp_gain <= `GAIN_MID;
            `HIGH_GAIN_MODE: amp_gain <= `GAIN_HIGH;
            default:         amp_gain <= `GAIN_OFF;
         endcase
      end
   end

   always @* begin
      state_next = state_reg;
      case (state_reg)
         `ST_RESET:
            state_next = `ST_PWRUP_WAIT;
         `ST_PWRUP_WAIT:
            if (pwrup_ok)
               state_next = ext_mode ? `ST_RUN : `ST_COUNT;
         `ST_COUNT:
            // Counter is disabled once the mode turns to an external clock
            if (ext_mode)
               state_next = `ST_RUN;
            else if (osc_rise && startup_cycle_counter == TERMINAL - 1'b1)
               state_next = `ST_RUN;
         `ST_RUN:
            if (sleep_wake_event && !ext_mode)
               state_next = `ST_COUNT;
         default:
            state_next = `ST_RESET;
      endcase
      if (any_reset)
         state_next = `ST_PWRUP_WAIT;
   end

   // Only the sampled pin edge moves the counter; a stopped clock
   // freezes it in place while the sys_clk registers keep running
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg             <= `ST_RESET;
         startup_cycle_counter <= {`CNT_W{1'b0}};
      end else begin
         state_reg <= state_next;
         if (state_reg != `ST_COUNT || state_next != `ST_COUNT)
            startup_cycle_counter <= {`CNT_W{1'b0}};
         else if (osc_rise)
            startup_cycle_counter <= startup_cycle_counter + 1'b1;
      end
   end

   // Core hold outputs
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         core_reset   <= 1'b1;
         pc_hold      <= 1'b1;
         startup_busy <= 1'b0;
      end else begin
         core_reset   <= (state_next == `ST_RESET) ||
                         (state_next == `ST_PWRUP_WAIT);
         pc_hold      <= (state_next != `ST_RUN);
         startup_busy <= (state_next == `ST_COUNT);
      end
   end

   // Vector load once the core leaves the hold after an interrupt wake
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_vec_pending_reg <= 1'b0;
         pc_load             <= 1'b0;
         pc_load_value       <= {`PC_W{1'b0}};
      end else begin
         pc_load <= 1'b0;
         if (any_reset)
            irq_vec_pending_reg <= 1'b0;
         else if (sleep_wake_event && wake_by_irq && global_irq_enable)
            irq_vec_pending_reg <= 1'b1;
         else if (irq_vec_pending_reg && state_next == `ST_RUN) begin
            irq_vec_pending_reg <= 1'b0;
            pc_load             <= 1'b1;
            pc_load_value       <= `IRQ_VECTOR;
         end
      end
   end

   // Wake source flags are sticky until nrst, a power-on or a brown-out reset
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_control_reg   <= 8'h00;
         periph_flag_reg_a <= 8'h00;
         periph_flag_reg_b <= 8'h00;
      end else if (por_event || bor_event) begin
         irq_control_reg   <= 8'h00;
         periph_flag_reg_a <= 8'h00;
         periph_flag_reg_b <= 8'h00;
      end else if (sleep_wake_event) begin
         irq_control_reg   <= irq_control_reg | wake_src_ctrl;
         periph_flag_reg_a <= periph_flag_reg_a | wake_src_a;
         periph_flag_reg_b <= periph_flag_reg_b | wake_src_b;
      end
   end

   // Cause bit survives every reset except nrst and brown-out
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         reset_cause_bor_n <= 1'b0;
      else if (bor_event)
         reset_cause_bor_n <= 1'b0;
      else if (bor_flag_set)
         reset_cause_bor_n <= 1'b1;
   end
endmodule // osc_startup_release

// *** rtl/osc_startup_map.vh ***
`ifndef OSC_STARTUP_MAP_VH
`define OSC_STARTUP_MAP_VH
// Oscillator mode codes
`define MODE_W              2
`define LOW_GAIN_MODE       2'h0
`define MID_GAIN_MODE       2'h1
`define HIGH_GAIN_MODE      2'h2
`define EXT_CLOCK_MODE      2'h3
// Amplifier drive gain codes
`define GAIN_OFF            2'h0
`define GAIN_LOW            2'h1
`define GAIN_MID            2'h2
`define GAIN_HIGH           2'h3
// Start-up count of oscillator cycles
`define STARTUP_CYCLES      1024
`define CNT_W               11
// Interrupt vector
`define PC_W                13
`define IRQ_VECTOR          13'h0004
// Reset-cause bit position
`define BROWNOUT_BIT        0
// Sequencer states
`define ST_W                2
`define ST_RESET            2'h0
`define ST_PWRUP_WAIT       2'h1
`define ST_COUNT            2'h2
`define ST_RUN              2'h3
`endif

// *** rtl/edge_rise_detect.v ***
`timescale 1ns/10ps
`include "osc_startup_map.vh"
// Synchronises a pin level and flags its rising edges
module edge_rise_detect (
   input  wire sys_clk,
   input  wire nrst,
   input  wire level_in,
   output wire rise_pulse
);
   reg meta_reg;
   reg sync_reg;
   reg last_reg;

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= level_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise_pulse = sync_reg & ~last_reg;
endmodule // edge_rise_detect

// *** verification/osc_source_model.sv ***
`timescale 1ns/10ps
// Logic-level clock source; parks low between bursts
module osc_source_model (
   input  wire logic run,
   output logic      osc,
   output int        rises
);
   initial osc = 1'b0;
   initial rises = 0;
   // Slow against sys_clk so each rise is seen once
   always begin
      #20;
      if (run) begin
         osc = ~osc;
         if (osc) rises++;
      end else
         osc = 1'b0;
   end
endmodule // osc_source_model

// *** verification/osc_startup_sva.sv ***
`timescale 1ns/10ps
module osc_startup_sva (
   input wire        sys_clk,
   input wire        nrst,
   input wire [1:0]  osc_mode,
   input wire        bor_event,
   input wire        startup_busy,
   input wire        pc_hold,
   input wire        pc_load,
   input wire [12:0] pc_load_value,
   input wire [1:0]  amp_gain,
   input wire        osc_out_gpio_en,
   input wire        reset_cause_bor_n,
   input wire [10:0] startup_cycle_counter
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_gain_map: assert property (osc_mode != 2'h3 |=>
      amp_gain == $past(osc_mode) + 2'h1) else $error("gain wrong");
   a_ext_gpio: assert property (osc_mode == 2'h3 |=>
      osc_out_gpio_en && amp_gain == 2'h0) else $error("ext pin wrong");
   a_count_hold: assert property (startup_busy |-> pc_hold)
      else $error("pc ran while counting");
   a_ext_nocount: assert property (osc_mode == 2'h3 |=> !startup_busy)
      else $error("count in ext mode");
   a_count_step: assert property (startup_busy && $past(startup_busy) |->
      startup_cycle_counter - $past(startup_cycle_counter) <= 11'h1)
      else $error("counter jumped");
   a_count_zero: assert property ($rose(startup_busy) |->
      startup_cycle_counter <= 11'h1) else $error("count not restarted");
   a_vec_value: assert property (pc_load |-> pc_load_value == 13'h0004)
      else $error("vector wrong");
   a_bor_clear: assert property (bor_event |=> !reset_cause_bor_n)
      else $error("cause bit kept");
endmodule // osc_startup_sva
bind osc_startup_release osc_startup_sva u_osc_startup_sva (.*);

// *** verification/test_osc_startup_release.sv ***
`timescale 1ns/10ps
module test_osc_startup_release;
   logic sys_clk = 0, nrst = 0, por_event = 0, bor_event = 0;
   logic other_reset_event = 0, pwrup_timer_enable = 1, run = 0;
   logic pwrup_timer_done = 0, sleep_wake_event = 0, wake_by_irq = 0;
   logic global_irq_enable = 0, bor_flag_set = 0, osc_in_pin;
   logic [1:0] osc_mode = 2'h0, amp_gain;
   logic [7:0] wake_src_a = 8'h00, periph_flag_reg_a;
   logic core_reset, pc_hold, pc_load, gpio_en, cause_n, busy;
   logic [12:0] pc_load_value;
   int err_total = 0, checked = 0, rises, r0, n;
   always #2 sys_clk = ~sys_clk;
   osc_source_model u_osc_source_model (.run(run), .osc(osc_in_pin),
      .rises(rises));
   osc_startup_release #(.STARTUP_CYCLES(8)) u_osc_startup_release (
      .sys_clk(sys_clk), .nrst(nrst), .osc_mode(osc_mode),
      .osc_in_pin(osc_in_pin), .por_event(por_event), .bor_event(bor_event),
      .other_reset_event(other_reset_event),
      .pwrup_timer_enable(pwrup_timer_enable),
      .pwrup_timer_done(pwrup_timer_done),
      .sleep_wake_event(sleep_wake_event), .wake_by_irq(wake_by_irq),
      .global_irq_enable(global_irq_enable), .wake_src_ctrl(8'h00),
      .wake_src_a(wake_src_a), .wake_src_b(8'h00),
      .bor_flag_set(bor_flag_set), .core_reset(core_reset),
      .pc_hold(pc_hold), .pc_load(pc_load), .pc_load_value(pc_load_value),
      .amp_gain(amp_gain), .osc_out_gpio_en(gpio_en),
      .irq_control_reg(), .periph_flag_reg_a(periph_flag_reg_a),
      .periph_flag_reg_b(), .reset_cause_bor_n(cause_n),
      .startup_busy(busy), .startup_cycle_counter());
   task conclude;
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string what, input logic [12:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // Bounded wait, sampled just after the edge has settled
   task wait_release;
      #1;
      for (n = 0; n < 900 && pc_hold !== 1'b0; n++) begin
         @(posedge sys_clk);
         #1;
      end
      if (n >= 900) err_total++;
   endtask
   initial begin
      #100000;
      err_total++;
      conclude;
   end
   initial begin
      cyc(16);
      nrst <= 1;
      cyc(10);
      #1 chk("hold_pwrup", core_reset, 1);
      cyc(1);
      pwrup_timer_done <= 1;
      cyc(4);
      #1 chk("core_reset", core_reset, 0);
      chk("busy", busy, 1);
      chk("gain_low", amp_gain, 1);
      for (int w = 0; w < 2; w++) begin
         cyc(1);
         r0 = rises;
         run <= 1;
         wake_src_a <= 8'h21;
         wake_by_irq <= 1;
         global_irq_enable <= 1;
         sleep_wake_event <= w[0];
         cyc(1);
         sleep_wake_event <= 0;
         wait_release;
         chk("pc_load", pc_load, w[0]);
         chk("pc_vector", pc_load_value, w[0] ? 13'h0004 : 13'h0000);
         chk("osc_rises", rises - r0, 8);
         run <= 0;
      end
      chk("wake_flag", periph_flag_reg_a, 8'h21);
      cyc(1);
      bor_flag_set <= 1;
      cyc(1);
      bor_flag_set <= 0;
      other_reset_event <= 1;
      cyc(1);
      other_reset_event <= 0;
      cyc(2);
      #1 chk("cause_keep", cause_n, 1);
      cyc(1);
      bor_event <= 1;
      cyc(1);
      bor_event <= 0;
      cyc(1);
      #1 chk("cause_clear", cause_n, 0);
      for (int m = 1; m < 3; m++) begin
         cyc(1);
         osc_mode <= m[1:0];
         cyc(3);
         #1 chk("gain", amp_gain, m + 1);
      end
      cyc(1);
      osc_mode <= 2'h3;
      por_event <= 1;
      cyc(1);
      por_event <= 0;
      cyc(8);
      #1 chk("ext_hold", pc_hold, 0);
      chk("ext_gpio", gpio_en, 1);
      chk("ext_gain", amp_gain, 0);
      conclude;
   end
endmodule // test_osc_startup_release
